/* File: bst_host.sv */
// test controller model: drives tck, tms, tdi and samples tdo
// assumes tdo settles within 4 core cycles of a tck fall
`timescale 1ns/100ps
module bst_host (
  // test pins
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  // tck parked low between frames, tdi idles at its pull-up level
  initial begin
    tck_out = 1'h0;
    tms_out = 1'h1;
    tdi_out = 1'h1;
  end
  // one period of 400 ns; tdo read just before the rise
  task automatic bit_step(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #200 tdo = tdo_in;
    tck_out = 1'h1;
    #200 tck_out = 1'h0;
  endtask
endmodule

/* File: bst_tap.sv */
// boundary scan test access port of a burst memory, sampled on the core clock
// assumes tck at most an eighth of core_clk_in; pad pull-ups on tms/tdi
// and the memory output mux sit outside, steered by the ring outputs
`timescale 1ns/100ps
`include "bst_tap_params.svh"
module bst_tap
  import bst_tap_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // test pins
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // pin ring
  input wire logic [`BST_RING_W-1:0] ring_pins_in,
  output logic [`BST_RING_W-1:0] ring_drive_out,
  output logic ring_drive_en_out,
  output logic q_bus_hiz_out
);

  function automatic bst_state_t bst_next(input bst_state_t s, input logic m);
    case (s)
      BST_TLR: bst_next = m ? BST_TLR : BST_RTI;
      BST_RTI: bst_next = m ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: bst_next = m ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: bst_next = m ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR: bst_next = m ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: bst_next = m ? BST_UPD_DR : BST_PA_DR;
      BST_PA_DR: bst_next = m ? BST_EX2_DR : BST_PA_DR;
      BST_EX2_DR: bst_next = m ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: bst_next = m ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: bst_next = m ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR: bst_next = m ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR: bst_next = m ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: bst_next = m ? BST_UPD_IR : BST_PA_IR;
      BST_PA_IR: bst_next = m ? BST_EX2_IR : BST_PA_IR;
      BST_EX2_IR: bst_next = m ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: bst_next = m ? BST_SEL_DR : BST_RTI;
      default: bst_next = BST_TLR;
    endcase
  endfunction

  // three-stage synchronisers; tms and tdi reset values mimic the pad pull-ups, tck resets low
  localparam bst_pins_t PINS_RST = '{tck: `BST_TCK_RST, tms: `BST_TMS_RST, tdi: `BST_TDI_RST};
  bst_pins_t s1_ff, s2_ff, s3_ff, st_ff;
  wire bst_pins_t pins_now = '{tck: tck_in, tms: tms_in, tdi: tdi_in};
  // a change counts only once stages two and three agree
  wire bst_pins_t nxt_st = (s2_ff & ~(s2_ff ^ s3_ff)) | (st_ff & (s2_ff ^ s3_ff));
  wire tck_rise = nxt_st.tck & ~st_ff.tck;
  wire tck_fall = ~nxt_st.tck & st_ff.tck;

  // first stage may go metastable; only stage two reads it
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_ff <= PINS_RST;
    end else begin
      s1_ff <= pins_now;
    end
  end

  // second stage
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s2_ff <= PINS_RST;
    end else begin
      s2_ff <= s1_ff;
    end
  end

  // third stage, compared against the second
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s3_ff <= PINS_RST;
    end else begin
      s3_ff <= s2_ff;
    end
  end

  // filtered levels; edges come from comparing against these
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_ff <= PINS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // controller state
  bst_state_t state_ff;
  wire bst_state_t nxt_state = tck_rise ? bst_next(state_ff, nxt_st.tms) : state_ff;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= BST_TLR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // instruction decode; unused codes fall to bypass
  logic [`BST_IR_W-1:0] ir_ff, ir_sh_ff;
  wire sel_ring = (ir_ff == `BST_INS_EXTEST) || (ir_ff == `BST_INS_SAMPLE_Z) ||
                  (ir_ff == `BST_INS_SAMPLE_PRE);
  wire sel_id = (ir_ff == `BST_INS_IDCODE);
  wire sel_byp = ~sel_ring & ~sel_id;
  wire is_extest = (ir_ff == `BST_INS_EXTEST);
  wire is_sample_z = (ir_ff == `BST_INS_SAMPLE_Z);

  wire at_tlr = tck_rise && (state_ff == BST_TLR);
  wire at_cap_ir = tck_rise && (state_ff == BST_CAP_IR);
  wire at_sh_ir = tck_rise && (state_ff == BST_SH_IR);
  wire at_upd_ir = tck_rise && (state_ff == BST_UPD_IR);
  wire at_cap_dr = tck_rise && (state_ff == BST_CAP_DR);
  wire at_sh_dr = tck_rise && (state_ff == BST_SH_DR);
  wire at_upd_dr = tck_rise && (state_ff == BST_UPD_DR);
  wire tdi_bit = nxt_st.tdi;

  // next values of the instruction path
  wire [`BST_IR_W-1:0] nxt_ir = at_tlr ? `BST_INS_IDCODE :
                                at_upd_ir ? ir_sh_ff : ir_ff;
  wire [`BST_IR_W-1:0] ir_shifted = {tdi_bit, ir_sh_ff[`BST_IR_W-1:1]};
  wire [`BST_IR_W-1:0] nxt_ir_sh = at_cap_ir ? `BST_IR_CAPTURE :
                                   at_sh_ir ? ir_shifted : ir_sh_ff;

  // current instruction; shifting never disturbs it until update
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ir_ff <= `BST_INS_IDCODE;
    end else begin
      ir_ff <= nxt_ir;
    end
  end

  // instruction shift stage
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ir_sh_ff <= `BST_IR_CAPTURE;
    end else begin
      ir_sh_ff <= nxt_ir_sh;
    end
  end

  // data registers; the id value is a constant, shift only moves a copy
  logic byp_ff;
  logic [`BST_ID_W-1:0] id_sh_ff;
  logic [`BST_RING_W-1:0] ring_sh_ff, ring_lat_ff;
  // ring is wider than the bonded pins; spare cells reserve positions
  localparam logic [`BST_RING_W-1:0] LAT_RST = `BST_RING_W'(1) << `BST_OE_CELL;

  // next values of the data registers; only the selected one moves, except the bypass cell clearing when bypass is loaded at update-IR
  wire byp_clear = (at_cap_dr && sel_byp) ||
                   (at_upd_ir && (ir_sh_ff == `BST_INS_BYPASS));
  wire nxt_byp = byp_clear ? 1'h0 :
                 (at_sh_dr && sel_byp) ? tdi_bit : byp_ff;
  wire [`BST_ID_W-1:0] id_shifted = {tdi_bit, id_sh_ff[`BST_ID_W-1:1]};
  wire [`BST_ID_W-1:0] nxt_id_sh = (at_cap_dr && sel_id) ? `BST_ID_VALUE :
                                   (at_sh_dr && sel_id) ? id_shifted : id_sh_ff;
  wire [`BST_RING_W-1:0] ring_shifted = {tdi_bit, ring_sh_ff[`BST_RING_W-1:1]};
  wire [`BST_RING_W-1:0] nxt_ring_sh = (at_cap_dr && sel_ring) ? ring_pins_in :
                                       (at_sh_dr && sel_ring) ? ring_shifted : ring_sh_ff;
  // latches change only at update or test-logic-reset, so pins stay still while shifting
  wire [`BST_RING_W-1:0] nxt_ring_lat = at_tlr ? LAT_RST :
                                        (at_upd_dr && sel_ring) ? ring_sh_ff : ring_lat_ff;

  // bypass cell
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      byp_ff <= 1'h0;
    end else begin
      byp_ff <= nxt_byp;
    end
  end

  // identification shift copy
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      id_sh_ff <= `BST_ID_VALUE;
    end else begin
      id_sh_ff <= nxt_id_sh;
    end
  end

  // ring shift stage
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ring_sh_ff <= '0;
    end else begin
      ring_sh_ff <= nxt_ring_sh;
    end
  end

  // ring preload latches; output-enable cell comes up high
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ring_lat_ff <= LAT_RST;
    end else begin
      ring_lat_ff <= nxt_ring_lat;
    end
  end

  // serial output picks the lsb of the one selected register
  wire in_ir_shift = (state_ff == BST_SH_IR);
  wire in_shift = in_ir_shift || (state_ff == BST_SH_DR);
  wire tdo_bit = in_ir_shift ? ir_sh_ff[0] :
                 sel_ring ? ring_sh_ff[0] :
                 sel_id ? id_sh_ff[0] : byp_ff;
  // pin steering registered so every output leaves a flip-flop
  wire nxt_drive_en = is_extest;
  wire nxt_hiz = is_sample_z || (is_extest && ~ring_lat_ff[`BST_OE_CELL]);

  logic tdo_ff, tdo_oe_ff, drive_en_ff, hiz_ff;
  // serial outputs move only on a detected fall
  wire nxt_tdo = tck_fall ? tdo_bit : tdo_ff;
  wire nxt_tdo_oe = tck_fall ? in_shift : tdo_oe_ff;

  // serial data out
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tdo_ff <= 1'h0;
    end else begin
      tdo_ff <= nxt_tdo;
    end
  end

  // tdo driver enable; off at power-up
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tdo_oe_ff <= 1'h0;
    end else begin
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  // output bus from latches; lags the instruction by one core cycle
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      drive_en_ff <= 1'h0;
    end else begin
      drive_en_ff <= nxt_drive_en;
    end
  end

  // output bus float request
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hiz_ff <= 1'h0;
    end else begin
      hiz_ff <= nxt_hiz;
    end
  end

  assign tdo_out = tdo_ff;
  assign tdo_oe_out = tdo_oe_ff;
  assign ring_drive_out = ring_lat_ff;
  assign ring_drive_en_out = drive_en_ff;
  assign q_bus_hiz_out = hiz_ff;

endmodule

/* File: bst_tap_monitor.sv */
// checker for the test port: output timing and pin steering
// assumes binding to bst_tap; tck phases last at least 4 core cycles
`timescale 1ns/100ps
`include "bst_tap_params.svh"
module bst_tap_monitor (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // test pins
  input wire logic tck_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  // pin ring
  input wire logic [`BST_RING_W-1:0] ring_drive_out,
  input wire logic ring_drive_en_out,
  input wire logic q_bus_hiz_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // the float flag lags the latch bit by one edge, so wait for both to settle
  sequence s_steer_settled;
    $stable({ring_drive_en_out, ring_drive_out[47]})[*2];
  endsequence
  a_tdo_on_fall: assert property ($changed(tdo_out) |-> !$past(tck_in, 2))
    else $error("tdo moved with tck high");
  a_oe_on_fall: assert property ($changed(tdo_oe_out) |-> !$past(tck_in, 2))
    else $error("tdo enable moved with tck high");
  a_oe_holds: assert property ($rose(tdo_oe_out) |=> $stable(tdo_oe_out)[*6])
    else $error("tdo enable glitched");
  a_latch_on_rise: assert property ($changed(ring_drive_out) |-> $past(tck_in, 2))
    else $error("latch moved with tck low");
  a_en_on_rise: assert property ($changed(ring_drive_en_out) |-> $past(tck_in, 3))
    else $error("drive enable moved off update");
  a_reset_quiet: assert property ($fell(reset_in) |->
    !tdo_oe_out && !ring_drive_en_out && !q_bus_hiz_out)
    else $error("outputs active after reset");
  a_reset_preset: assert property ($fell(reset_in) |->
    ring_drive_out == 64'h0000_8000_0000_0000)
    else $error("latch not preset");
  a_hiz_when_off: assert property (s_steer_settled ##0
    (ring_drive_en_out && !ring_drive_out[47]) |-> q_bus_hiz_out)
    else $error("bus not floated");
  a_drive_when_on: assert property (s_steer_settled ##0
    (ring_drive_en_out && ring_drive_out[47]) |-> !q_bus_hiz_out)
    else $error("bus floated under drive");
endmodule
bind bst_tap bst_tap_monitor u_mon (.core_clk_in(core_clk_in), .reset_in(reset_in),
  .tck_in(tck_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .ring_drive_out(ring_drive_out),
  .ring_drive_en_out(ring_drive_en_out), .q_bus_hiz_out(q_bus_hiz_out));

/* File: bst_tap_params.svh */
// constants of the boundary scan test port: codes, widths, reset values
// assumes inclusion by bst_tap_pkg, the tap module, its monitor and the bench
`ifndef BST_TAP_PARAMS_SVH
`define BST_TAP_PARAMS_SVH
`define BST_IR_W 3
`define BST_ID_W 32
`define BST_RING_W 64
`define BST_OE_CELL 47
`define BST_INS_EXTEST 3'h0
`define BST_INS_IDCODE 3'h1
`define BST_INS_SAMPLE_Z 3'h2
`define BST_INS_SAMPLE_PRE 3'h4
`define BST_INS_BYPASS 3'h7
`define BST_IR_CAPTURE 3'h1
// identification value is arbitrary, not a real maker code
`define BST_ID_VALUE 32'h1234_5679
`define BST_TCK_RST 1'h0
`define BST_TMS_RST 1'h1
`define BST_TDI_RST 1'h1
`endif

/* File: bst_tap_pkg.sv */
// types of the boundary scan test port
// assumes bst_tap_params.svh is on the include path
`include "bst_tap_params.svh"
package bst_tap_pkg;
  typedef enum logic [3:0] {
    BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR,
    BST_PA_DR, BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR,
    BST_SH_IR, BST_EX1_IR, BST_PA_IR, BST_EX2_IR, BST_UPD_IR
  } bst_state_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;
endpackage

/* File: test_bst_tap.sv */
// bench for bst_tap: scans every code through the host model, then resets
// assumes bst_host and bst_tap_monitor are compiled alongside
`timescale 1ns/100ps
`include "bst_tap_params.svh"
module test_bst_tap;
  typedef struct packed {
    logic [2:0] ir;
    logic [6:0] n;
    logic [63:0] din, dout, lat;
    logic en, hiz;
  } bst_row_t;
  localparam logic [63:0] pins_val = 64'hC3A5_0F1E_8421_7BDE;
  localparam logic [63:0] pre_a = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] pre_b = 64'h0123_C567_89AB_CDEF;
  logic core_clk_in = 1'h0;
  logic reset_in = 1'h1;
  logic tck, tms, tdi, tdo, tdo_oe, drive_en, hiz, t;
  logic [63:0] drive, seen;
  int fail_count = 0;
  int check_count = 0;
  bst_row_t rows [8];
  // released tdo floats, so a read outside shift shows up as a mismatch
  wire tdo_pin = tdo_oe ? tdo : 1'bz;
  bst_tap u_dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .ring_pins_in(pins_val),
    .ring_drive_out(drive), .ring_drive_en_out(drive_en), .q_bus_hiz_out(hiz));
  bst_host u_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_pin));
  initial begin
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic check(input string name, input logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // from idle through capture and shift, lsb first, back to idle
  task automatic scan(input logic ir, input logic [6:0] n, input logic [63:0] din,
    output logic [63:0] dout);
    dout = '0;
    u_host.bit_step(1'h1, 1'h1, t);
    if (ir) u_host.bit_step(1'h1, 1'h1, t);
    u_host.bit_step(1'h0, 1'h1, t);
    u_host.bit_step(1'h0, 1'h1, t);
    for (int i = 0; i < n; i++) begin
      u_host.bit_step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    u_host.bit_step(1'h1, 1'h1, t);
    u_host.bit_step(1'h0, 1'h1, t);
    #400;
  endtask
  initial begin
    rows[0] = '{`BST_INS_SAMPLE_PRE, 7'h40, pre_a, pins_val, pre_a, 1'h0, 1'h0};
    rows[1] = '{`BST_INS_EXTEST, 7'h40, pre_b, pins_val, pre_b, 1'h1, 1'h0};
    rows[2] = '{`BST_INS_SAMPLE_Z, 7'h40, pre_a, pins_val, pre_a, 1'h0, 1'h1};
    rows[3] = '{`BST_INS_IDCODE, 7'h20, 64'h0, {32'h0, `BST_ID_VALUE}, pre_a, 1'h0, 1'h0};
    rows[4] = '{`BST_INS_BYPASS, 7'h08, 64'hA5, 64'h4A, pre_a, 1'h0, 1'h0};
    rows[5] = '{3'h3, 7'h08, 64'hA5, 64'h4A, pre_a, 1'h0, 1'h0};
    rows[6] = '{3'h5, 7'h08, 64'hA5, 64'h4A, pre_a, 1'h0, 1'h0};
    rows[7] = '{3'h6, 7'h08, 64'hA5, 64'h4A, pre_a, 1'h0, 1'h0};
    repeat (4) @(posedge core_clk_in);
    #1 reset_in = 1'h0;
    check("reset steer", {drive_en, hiz, tdo_oe}, 3'h0);
    check("reset latch", drive, 64'h0000_8000_0000_0000);
    repeat (4) @(posedge core_clk_in);
    #1 u_host.bit_step(1'h0, 1'h1, t);
    foreach (rows[i]) begin
      scan(1'h1, 7'h03, {61'h0, rows[i].ir}, seen);
      check("ir capture", seen[2:0], `BST_IR_CAPTURE);
      scan(1'h0, rows[i].n, rows[i].din, seen);
      check("scan out", seen, rows[i].dout);
      check("latch", drive, rows[i].lat);
      check("steer", {drive_en, hiz, tdo_oe}, {rows[i].en, rows[i].hiz, 1'h0});
    end
    // latch bit 47 is low here, so external test must float the bus
    scan(1'h1, 7'h03, {61'h0, `BST_INS_EXTEST}, seen);
    check("extest float", {drive_en, hiz}, 2'h3);
    repeat (5) u_host.bit_step(1'h1, 1'h1, t);
    #400;
    check("tlr latch", drive, 64'h0000_8000_0000_0000);
    check("tlr steer", {drive_en, hiz}, 2'h0);
    u_host.bit_step(1'h0, 1'h1, t);
    scan(1'h0, 7'h20, 64'h0, seen);
    check("id after tlr", seen, {32'h0, `BST_ID_VALUE});
    test_done();
  end
  initial begin
    #2000000;
    fail_count++;
    test_done();
  end
endmodule
